// ### logic/smri_pkg.sv
// Shared constants and types for the serial master register interface
package smri_pkg;

  // ==========================================================================
  // Register word addresses
  localparam logic [2:0] RXBUF_ADDR   = 3'h0;
  localparam logic [2:0] TXBUF_ADDR   = 3'h1;
  localparam logic [2:0] STATUS_ADDR  = 3'h2;
  localparam logic [2:0] IEN_ADDR     = 3'h3;
  localparam logic [2:0] RSVD_ADDR    = 3'h4;
  localparam logic [2:0] MASK_ADDR    = 3'h5;

  // ==========================================================================
  // Bit positions shared by status_flags and interrupt_enables
  localparam int ROE_BIT  = 3;
  localparam int TOE_BIT  = 4;
  localparam int TMT_BIT  = 5;
  localparam int TRDY_BIT = 6;
  localparam int RRDY_BIT = 7;
  localparam int ERR_BIT  = 8;

  // Status positions that may raise the interrupt request
  localparam logic [15:0] IRQ_SRC_MASK = 16'h01D8;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] IEN_RESET  = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'h0001;
  localparam logic [15:0] WORD_ZERO  = 16'h0000;
  localparam logic [15:0] SS_N_IDLE  = 16'hFFFF;

  // ==========================================================================
  // Register port request from the bus master
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [2:0]  addr;
    logic [15:0] wdata;
  } smri_req_t;

  // Word passed between the register file and the shift engine
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } smri_word_t;

  // State of one sticky flag
  typedef struct packed {
    logic q;
  } smri_flag_st_t;

  // State of the transmit holding stage
  typedef struct packed {
    logic [15:0] data;
    logic        full;
    smri_word_t  load;
  } smri_tx_st_t;

  // State of the register interface top
  typedef struct packed {
    logic [15:0] rx_buf;
    logic [15:0] ien;
    logic [15:0] mask;
    logic [15:0] rdata;
    logic [15:0] ss_n;
    logic        active;
    logic        irq;
  } smri_top_st_t;

endpackage

// ### logic/smri_flag.sv
// Sticky status flag where a set beats a simultaneous clear
`timescale 1ns/10ps
module smri_flag
  import smri_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic srst_i,
  // Control
  input  wire logic set_i,
  input  wire logic clr_i,
  // Flag
  output logic      q_o
);

  smri_flag_st_t st_reg;
  smri_flag_st_t st_next;

  always_comb begin
    st_next = st_reg;
    // An event landing on the clearing cycle must not be lost
    if (set_i) begin
      st_next.q = 1'b1;
    end else if (clr_i) begin
      st_next.q = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_reg.q <= RESET_VAL;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.q;

endmodule

// ### logic/smri_txhold.sv
// Transmit holding register with hand-off to the shift engine
`timescale 1ns/10ps
module smri_txhold
  import smri_pkg::*;
#(
  parameter int DATA_WIDTH = 8
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  // Bus side
  input  wire logic        wr_i,
  input  wire logic [15:0] wdata_i,
  output logic             ready_o,
  output logic             overrun_o,
  // Shifter side
  input  wire logic        shifter_free_i,
  output smri_word_t       load_o
);

  localparam logic [15:0] DATA_MASK = 16'((32'h1 << DATA_WIDTH) - 32'h1);

  smri_tx_st_t st_reg;
  smri_tx_st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.load.valid = 1'b0;
    // Hand the held word over once the shifter can take it
    if (st_reg.full && shifter_free_i) begin // [R8] [R11]
      st_next.load.valid = 1'b1;
      st_next.load.data  = st_reg.data;
      st_next.full       = 1'b0;
    end
    // A write to a full holding register is dropped
    if (wr_i && !st_reg.full) begin // [R7] [R9]
      st_next.data = wdata_i & DATA_MASK; // [R3]
      st_next.full = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_reg.data <= WORD_ZERO;
      st_reg.full <= 1'b0;
      st_reg.load <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ready_o   = ~st_reg.full; // [R22]
  assign overrun_o = wr_i & st_reg.full; // [R9]
  assign load_o    = st_reg.load;

endmodule

// ### logic/smri_top.sv
// Register interface of the serial peripheral master core
//
// Notes on behaviour
// R1: Six 16-bit registers face the bus master.
// R2: Word addresses zero to five, fixed order.
// R3: Data in low n bits only.
// R4: Received word loads buffer, sets receive-ready.
// R5: Reading receive buffer clears receive-ready.
// R6: Receive while ready sets receive-overrun.
// R7: Transmit buffer write clears transmit-ready.
// R8: Hand-off to shifter sets transmit-ready again.
// R9: Write while not ready sets transmit-overrun.
// R10: Master waits for transmit-ready before writing.
// R11: Second word waits until current shift ends.
// R12: Status reads leave every flag unchanged.
// R13: Any status write clears error flags.
// R14: Shifter-empty is low during a shift.
// R15: Error summary is OR of overruns.
// R16: Enable bits sit at status flag positions.
// R17: Target mask exists only in master mode.
// R18: Interrupt when flag and enable both set; the shifter-empty flag never raises it here.
// R19: Reset clears all interrupt enables.
// R20: Mask bits pick selects during a shift.
// R21: Reset mask selects target zero only.
// R22: Reset shows transmit-ready and shifter-empty only.
// R23: Enable register stores written values exactly.
`timescale 1ns/10ps
module smri_top
  import smri_pkg::*;
#(
  parameter int DATA_WIDTH  = 8,
  parameter int NUM_TARGETS = 1,
  parameter bit MASTER_MODE = 1'b1
) (
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   srst_i,

  // Register port
  input  wire smri_req_t              req_i,
  output logic [15:0]                 rdata_o,

  // Shift engine, transmit direction
  output smri_word_t                  shift_load_o,
  input  wire logic                   shift_done_i,

  // Shift engine, receive direction
  input  wire smri_word_t             rx_word_i,

  // Target selects and interrupt
  output logic [NUM_TARGETS-1:0]      ss_n_o,
  output logic                        irq_o
);

  // ==========================================================================
  // Constants
  localparam logic [15:0] DATA_MASK = 16'((32'h1 << DATA_WIDTH) - 32'h1);
  localparam logic [15:0] TGT_MASK  = 16'((32'h1 << NUM_TARGETS) - 32'h1);

  // ==========================================================================
  // Decoded accesses
  logic rd_rx;
  logic wr_tx;
  logic wr_status;
  logic wr_ien;
  logic wr_mask;

  assign rd_rx     = req_i.rd && (req_i.addr == RXBUF_ADDR); // [R2] [R5]
  assign wr_tx     = req_i.wr && (req_i.addr == TXBUF_ADDR); // [R2]
  assign wr_status = req_i.wr && (req_i.addr == STATUS_ADDR); // [R2] [R13]
  assign wr_ien    = req_i.wr && (req_i.addr == IEN_ADDR); // [R2]
  assign wr_mask   = req_i.wr && (req_i.addr == MASK_ADDR) && MASTER_MODE; // [R17]

  // ==========================================================================
  // State
  smri_top_st_t st_reg;
  smri_top_st_t st_next;

  // ==========================================================================
  // Status flags
  logic rrdy;
  logic roe;
  logic toe;
  logic trdy;
  logic tx_overrun;
  logic shifter_free;
  logic err;
  logic shifter_empty_flag;

  // A word finishing its shift frees the shifter in the same cycle,
  // so back-to-back words are separated by one idle cycle on the serial side
  assign shifter_free = ~st_reg.active | shift_done_i; // [R11]

  smri_flag #(
    .RESET_VAL (1'b0)
  ) u_rrdy (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .set_i     (rx_word_i.valid), // [R4]
    .clr_i     (rd_rx), // [R5]
    .q_o       (rrdy)
  );

  smri_flag #(
    .RESET_VAL (1'b0)
  ) u_roe (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .set_i     (rx_word_i.valid & rrdy), // [R6]
    .clr_i     (wr_status), // [R13]
    .q_o       (roe)
  );

  smri_flag #(
    .RESET_VAL (1'b0)
  ) u_toe (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .set_i     (tx_overrun), // [R9]
    .clr_i     (wr_status), // [R13]
    .q_o       (toe)
  );

  // ==========================================================================
  // Transmit holding stage
  smri_txhold #(
    .DATA_WIDTH (DATA_WIDTH)
  ) u_txhold (
    .sys_clk_i      (sys_clk_i),
    .srst_i         (srst_i),
    .wr_i           (wr_tx),
    .wdata_i        (req_i.wdata),
    .ready_o        (trdy),
    .overrun_o      (tx_overrun),
    .shifter_free_i (shifter_free),
    .load_o         (shift_load_o)
  );

  assign err = roe | toe; // [R15]
  assign shifter_empty_flag = ~st_reg.active; // [R14]

  // ==========================================================================
  // Status word, shared by the read path and the interrupt request
  logic [15:0] status_word;

  always_comb begin
    status_word           = WORD_ZERO;
    status_word[ROE_BIT]  = roe;
    status_word[TOE_BIT]  = toe;
    status_word[TMT_BIT]  = shifter_empty_flag;
    status_word[TRDY_BIT] = trdy;
    status_word[RRDY_BIT] = rrdy;
    status_word[ERR_BIT]  = err; // [R15]
  end

  // ==========================================================================
  // Read multiplexer
  logic [15:0] rd_word;

  always_comb begin
    rd_word = WORD_ZERO;
    unique case (req_i.addr)
      RXBUF_ADDR: begin
        rd_word = st_reg.rx_buf & DATA_MASK; // [R3]
      end
      STATUS_ADDR: begin
        rd_word = status_word; // [R12]
      end
      IEN_ADDR: begin
        rd_word = st_reg.ien; // [R23]
      end
      MASK_ADDR: begin
        if (MASTER_MODE) begin // [R17]
          rd_word = st_reg.mask;
        end
      end
      // Transmit buffer is write-only; reserved and unmapped read zero
      default: begin
        rd_word = WORD_ZERO;
      end
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    st_next = st_reg;

    // Receive buffer always takes a new word, even over an unread one
    if (rx_word_i.valid) begin // [R4] [R6]
      st_next.rx_buf = rx_word_i.data & DATA_MASK; // [R3]
    end

    // Shifter occupancy; a new load outranks the end of the old word
    if (shift_load_o.valid) begin // [R14]
      st_next.active = 1'b1;
    end else if (shift_done_i) begin
      st_next.active = 1'b0;
    end

    if (wr_ien) begin
      st_next.ien = req_i.wdata; // [R16] [R23]
    end

    if (wr_mask) begin
      st_next.mask = req_i.wdata & TGT_MASK; // [R20]
    end

    // Read data is held until the next read
    if (req_i.rd) begin
      st_next.rdata = rd_word; // [R1]
    end

    // Selects follow the mask only while a word is being shifted
    if (st_reg.active) begin // [R20]
      st_next.ss_n = ~(st_reg.mask & TGT_MASK);
    end else begin
      st_next.ss_n = SS_N_IDLE;
    end

    st_next.irq = |(status_word & st_reg.ien & IRQ_SRC_MASK); // [R18]
  end

  // ==========================================================================
  // State register
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_reg.rx_buf <= WORD_ZERO;
      st_reg.ien    <= IEN_RESET; // [R19]
      st_reg.mask   <= MASTER_MODE ? MASK_RESET : WORD_ZERO; // [R21]
      st_reg.rdata  <= WORD_ZERO;
      st_reg.ss_n   <= SS_N_IDLE; // [R20]
      st_reg.active <= 1'b0; // [R22]
      st_reg.irq    <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign rdata_o = st_reg.rdata;
  assign ss_n_o  = st_reg.ss_n[NUM_TARGETS-1:0];
  assign irq_o   = st_reg.irq;

endmodule

// ### sim/smri_chk.sv
// Assertion checker bound to the register interface top
`timescale 1ns/10ps
module smri_chk
  import smri_pkg::*;
#(
  parameter int NUM_TARGETS = 1,
  parameter int DATA_WIDTH  = 8
) (
  // Clock and reset
  input wire logic                   sys_clk_i,
  input wire logic                   srst_i,
  // Watched ports
  input wire smri_req_t              req_i,
  input wire logic [15:0]            rdata_o,
  input wire smri_word_t             shift_load_o,
  input wire smri_word_t             rx_word_i,
  input wire logic [NUM_TARGETS-1:0] ss_n_o,
  input wire logic                   irq_o
);
  // ====
  // Request decode
  logic rd_st;
  logic wr_st;
  assign rd_st = req_i.rd && req_i.addr == STATUS_ADDR;
  assign wr_st = req_i.wr && req_i.addr == STATUS_ADDR;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  // ====
  // Properties
  reset_idle_a: assert property (
    $fell(srst_i) |-> !irq_o && &ss_n_o && rdata_o == WORD_ZERO)
    else $error("outputs not idle after reset");
  load_width_a: assert property (
    shift_load_o.valid |-> (shift_load_o.data >> DATA_WIDTH) == WORD_ZERO)
    else $error("load carries bits above width");
  rx_set_a: assert property (
    rx_word_i.valid ##1 rd_st |=> rdata_o[RRDY_BIT])
    else $error("receive ready not set");
  rx_clear_a: assert property (
    (req_i.rd && req_i.addr == RXBUF_ADDR && !rx_word_i.valid) ##1 rd_st
    |=> !rdata_o[RRDY_BIT]) else $error("receive ready not cleared");
  err_sum_a: assert property (
    rd_st |=> rdata_o[ERR_BIT] == (rdata_o[TOE_BIT] || rdata_o[ROE_BIT]))
    else $error("error summary mismatch");
  st_clear_a: assert property (
    (wr_st && !rx_word_i.valid) ##1 rd_st
    |=> !rdata_o[ROE_BIT] && !rdata_o[TOE_BIT] && !rdata_o[ERR_BIT])
    else $error("status write left error flags");
  tx_clear_a: assert property (
    (req_i.wr && req_i.addr == TXBUF_ADDR) ##1 rd_st |=> !rdata_o[TRDY_BIT])
    else $error("transmit ready not cleared");
  ien_rw_a: assert property (
    (req_i.wr && req_i.addr == IEN_ADDR) ##1 (req_i.rd && req_i.addr == IEN_ADDR)
    |=> rdata_o == $past(req_i.wdata, 2)) else $error("enable readback mismatch");
endmodule

bind smri_top smri_chk #(.NUM_TARGETS(NUM_TARGETS), .DATA_WIDTH(DATA_WIDTH)) i_smri_chk (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .req_i(req_i), .rdata_o(rdata_o),
  .shift_load_o(shift_load_o), .rx_word_i(rx_word_i), .ss_n_o(ss_n_o), .irq_o(irq_o));

// ### sim/smri_shift_model.sv
// Behavioural shift engine that loops each sent word back as received
`timescale 1ns/10ps
module smri_shift_model
  import smri_pkg::*;
#(
  parameter logic [7:0] DELAY = 8'h28
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  // Engine side
  input  wire smri_word_t load_i,
  output logic            done_o,
  output smri_word_t      rx_o
);
  logic [7:0]  cnt_reg;
  logic [15:0] data_reg;

  // Data outside a valid pulse flips each cycle so nothing may rely on it
  always @(posedge sys_clk_i) begin
    done_o     <= 1'b0;
    rx_o.valid <= 1'b0;
    rx_o.data  <= ~rx_o.data;
    if (srst_i) begin
      cnt_reg   <= 8'h00;
      rx_o.data <= 16'h0000;
    end else if (load_i.valid) begin
      cnt_reg  <= DELAY;
      data_reg <= load_i.data;
    end else if (cnt_reg == 8'h01) begin
      cnt_reg <= 8'h00;
      done_o  <= 1'b1;
      rx_o    <= {1'b1, data_reg};
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the serial master register interface
`timescale 1ns/10ps
module tb_top;
  import smri_pkg::*;
  logic        sys_clk_i   = 1'b0;
  logic        srst_i      = 1'b1;
  smri_req_t   req_i       = '0;
  logic [15:0] rdata_o;
  smri_word_t  shift_load_o;
  logic        shift_done_i;
  smri_word_t  rx_word_i;
  logic [1:0]  ss_n_o;
  logic        irq_o;
  int          n_errors    = 0;
  int          comparisons = 0;

  always #25 sys_clk_i = ~sys_clk_i;

  smri_top #(.NUM_TARGETS(2)) i_smri_top (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .req_i(req_i), .rdata_o(rdata_o),
    .shift_load_o(shift_load_o), .shift_done_i(shift_done_i),
    .rx_word_i(rx_word_i), .ss_n_o(ss_n_o), .irq_o(irq_o));
  smri_shift_model i_smri_shift_model (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .load_i(shift_load_o),
    .done_o(shift_done_i), .rx_o(rx_word_i));

  // ====
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic put(input logic r, input logic [2:0] a, input logic [15:0] v);
    @(posedge sys_clk_i) req_i <= '{r, !r, a, v};
  endtask

  // Drops the strobe, then lets the taking edge's updates settle
  task automatic idle();
    @(posedge sys_clk_i) req_i <= '0;
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    put(1'b0, a, v);
    idle();
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    put(1'b1, a, 16'h0000);
    idle();
    chk(rdata_o, e);
  endtask

  // Bounded wait for a load pulse (ld high) or a finished shift
  task automatic wait_ev(input logic ld, input logic [15:0] e);
    repeat (200) begin
      if ((ld ? shift_load_o.valid : shift_done_i) === 1'b1) begin
        if (ld)
          chk(shift_load_o.data, e);
        return;
      end
      @(posedge sys_clk_i);
      #1;
    end
    n_errors++;
    $display("BAD %0t shift engine wait ran out", $time);
    final_report();
  endtask

  // ====
  // Scenarios
  task automatic t_reset();
    rd(STATUS_ADDR, 16'h0060);
    rd(IEN_ADDR, 16'h0000);
    rd(MASK_ADDR, 16'h0001);
    rd(RSVD_ADDR, 16'h0000);
    wr(RXBUF_ADDR, 16'h00FF);
    rd(STATUS_ADDR, 16'h0060);
    $display("t_reset done");
  endtask

  task automatic t_irq();
    put(1'b0, IEN_ADDR, 16'h01D8);
    put(1'b1, IEN_ADDR, 16'h0000);
    idle();
    chk(rdata_o, 16'h01D8);
    chk({15'h0000, irq_o}, 16'h0001);
    wr(IEN_ADDR, 16'h0098);
    rd(IEN_ADDR, 16'h0098);
    chk({15'h0000, irq_o}, 16'h0000);
    $display("t_irq done");
  endtask

  task automatic t_tx();
    chk({14'h0000, ss_n_o}, 16'h0003);
    put(1'b0, TXBUF_ADDR, 16'hA53C);
    put(1'b1, STATUS_ADDR, 16'h0000);
    idle();
    chk(rdata_o, 16'h0020);
    wait_ev(1'b1, 16'h003C);
    rd(STATUS_ADDR, 16'h0040);
    chk({14'h0000, ss_n_o}, 16'h0002);
    put(1'b0, TXBUF_ADDR, 16'h0055);
    put(1'b1, STATUS_ADDR, 16'h0000);
    idle();
    chk(rdata_o, 16'h0000);
    wr(TXBUF_ADDR, 16'h0077);
    rd(STATUS_ADDR, 16'h0110);
    chk({15'h0000, irq_o}, 16'h0001);
    wait_ev(1'b1, 16'h0055);
    rd(STATUS_ADDR, 16'h01D0);
    rd(RXBUF_ADDR, 16'h003C);
    put(1'b0, STATUS_ADDR, 16'h0000);
    put(1'b1, STATUS_ADDR, 16'h0000);
    idle();
    chk(rdata_o, 16'h0040);
    wait_ev(1'b0, 16'h0000);
    rd(STATUS_ADDR, 16'h00E0);
    $display("t_tx done");
  endtask

  task automatic t_rx();
    wr(TXBUF_ADDR, 16'h0011);
    wait_ev(1'b0, 16'h0000);
    rd(STATUS_ADDR, 16'h01E8);
    rd(STATUS_ADDR, 16'h01E8);
    put(1'b1, RXBUF_ADDR, 16'h0000);
    put(1'b1, STATUS_ADDR, 16'h0000);
    idle();
    chk(rdata_o, 16'h0168);
    wr(STATUS_ADDR, 16'hFFFF);
    rd(STATUS_ADDR, 16'h0060);
    $display("t_rx done");
  endtask

  // Mask keeps only the implemented selects and steers them during a shift
  task automatic t_mask();
    wr(MASK_ADDR, 16'hFFFF);
    rd(MASK_ADDR, 16'h0003);
    wr(TXBUF_ADDR, 16'h0022);
    wait_ev(1'b1, 16'h0022);
    rd(MASK_ADDR, 16'h0003);
    chk({14'h0000, ss_n_o}, 16'h0000);
    wait_ev(1'b0, 16'h0000);
    rd(STATUS_ADDR, 16'h00E0);
    chk({14'h0000, ss_n_o}, 16'h0003);
    chk({15'h0000, irq_o}, 16'h0001);
    $display("t_mask done");
  endtask

  // ====
  // Main sequence, with a second reset in mid-run
  initial begin
    repeat (3) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_irq();
    t_tx();
    t_rx();
    t_mask();
    @(posedge sys_clk_i) srst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    t_reset();
    final_report();
  end
endmodule
